// [common/afir_pkg.sv]
// Overview of operation
// - clear iir shift registers pixel after hstart match
// - base address 32 bits, low six ignored
// - new base address applies from next frame
// - base address read returns latest written value
// - coefficients are 12-bit signed, six fraction bits
// - two taps per word, reserved bits read zero
// - set zero has eleven taps, tap ten alone
// - second set packed like the first
package afir_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;
	localparam int TAP_W = 12;
	localparam int HPOS_W = 12;
	localparam int NUM_TAPS = 11;
	localparam int NUM_WORDS = 6;
	// byte offsets of the register map
	localparam logic [ADDR_W-1:0] OFF_HSTART = 6'h00;
	localparam logic [ADDR_W-1:0] OFF_BASE = 6'h04;
	localparam logic [ADDR_W-1:0] OFF_SET0 = 6'h08;
	localparam logic [ADDR_W-1:0] OFF_SET1 = 6'h20;
	localparam int BASE_IGNORE = 6;
	localparam int HI_LSB = 16;
	localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
	localparam logic [DATA_W-1:0] PAIR_MASK = 32'h0FFF_0FFF;
	localparam logic [DATA_W-1:0] HSTART_MASK = 32'h0000_0FFF;
	localparam logic [DATA_W-1:0] BASE_MASK = 32'hFFFF_FFC0;

	typedef logic signed [TAP_W-1:0] afir_tap_t;
	typedef struct packed {
		logic read;
		logic write;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] writedata;
	} afir_req_s;
	typedef struct packed {
		afir_tap_t [NUM_TAPS-1:0] set0;
		afir_tap_t [NUM_TAPS-1:0] set1;
	} afir_coef_s;
endpackage

// [hw/afir_coef_bank.sv]
`timescale 1ns/10ps
module afir_coef_bank (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// write port
	input wire logic i_we,
	input wire logic [2:0] i_word,
	input wire logic [afir_pkg::DATA_W-1:0] i_wdata,
	// read and tap outputs
	input wire logic [2:0] i_rword,
	output logic [afir_pkg::DATA_W-1:0] o_rdata,
	output afir_pkg::afir_tap_t [afir_pkg::NUM_TAPS-1:0] o_taps
);
	import afir_pkg::*;
	logic [DATA_W-1:0] mem [NUM_WORDS];
	genvar g;
	generate
		for (g = 0; g < NUM_WORDS; g++) begin : g_word
			always_ff @(posedge i_clk) begin
				if (i_srst) begin
					mem[g] <= RST_WORD;
				end else if (i_we && i_word == 3'(g)) begin
					mem[g] <= i_wdata & PAIR_MASK;
				end
			end
		end
		// tap 2k low, 2k+1 high; last word holds tap ten only
		for (g = 0; g < NUM_TAPS; g++) begin : g_tap
			assign o_taps[g] = mem[g/2][(g%2)*HI_LSB +: TAP_W];
		end
	endgenerate
	// upper half of last word is reserved
	wire last_rd = i_rword == 3'(NUM_WORDS-1);
	wire in_rng = i_rword < 3'(NUM_WORDS);
	assign o_rdata = !in_rng ? RST_WORD :
		last_rd ? (mem[NUM_WORDS-1] & HSTART_MASK) : mem[i_rword];
endmodule

// [hw/afir_hstart_clear.sv]
`timescale 1ns/10ps
module afir_hstart_clear (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// pixel timing
	input wire logic i_pix_valid,
	input wire logic [afir_pkg::HPOS_W-1:0] i_hpos,
	input wire logic [afir_pkg::HPOS_W-1:0] i_hstart,
	output logic o_clear
);
	import afir_pkg::*;
	logic armed;
	wire hit = i_pix_valid && i_hpos == i_hstart;
	// clear lands on the next valid pixel, not the matching one
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			armed <= 1'b0;
			o_clear <= 1'b0;
		end else begin
			o_clear <= armed && i_pix_valid;
			if (i_pix_valid) begin
				armed <= hit;
			end
		end
	end
endmodule

// [hw/afir_setup_regs.sv]
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module afir_setup_regs (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// avalon-mm slave
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [afir_pkg::ADDR_W-1:0] i_address,
	input wire logic [afir_pkg::DATA_W-1:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [afir_pkg::DATA_W-1:0] o_readdata,
	output logic o_waitrequest,
	output logic [1:0] o_response,
	// video timing
	input wire logic i_frame_start,
	input wire logic i_pix_valid,
	input wire logic [afir_pkg::HPOS_W-1:0] i_hpos,
	// to the filter engine
	output logic o_iir_clear,
	output logic [afir_pkg::HPOS_W-1:0] o_iir_hstart,
	output logic [afir_pkg::DATA_W-1:0] o_active_base,
	output afir_pkg::afir_coef_s o_coef
);
	import afir_pkg::*;
	logic [HPOS_W-1:0] iir_hstart;
	logic [DATA_W-1:0] pending_base;
	logic done;
	afir_req_s req;
	afir_tap_t [NUM_TAPS-1:0] taps0;
	afir_tap_t [NUM_TAPS-1:0] taps1;
	logic [DATA_W-1:0] rd0;
	logic [DATA_W-1:0] rd1;
	logic [DATA_W-1:0] next_readdata;

	function automatic logic [DATA_W-1:0] lanes(
		input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v,
		input logic [3:0] be);
		logic [DATA_W-1:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	assign req = '{read: i_read, write: i_write, address: i_address,
		writedata: i_writedata};
	// one wait cycle per access keeps readdata a flop output
	wire access = (req.read || req.write) && !done;
	wire wr_go = req.write && !done;
	wire [3:0] word = 4'(req.address[ADDR_W-1:2]);
	wire hit_hs = word == 4'(OFF_HSTART >> 2);
	wire hit_base = word == 4'(OFF_BASE >> 2);
	wire hit_s0 = word >= 4'(OFF_SET0 >> 2) &&
		word < 4'((OFF_SET0 >> 2) + NUM_WORDS);
	wire hit_s1 = word >= 4'(OFF_SET1 >> 2) &&
		word < 4'((OFF_SET1 >> 2) + NUM_WORDS);
	wire mapped = hit_hs || hit_base || hit_s0 || hit_s1;
	wire [2:0] idx0 = 3'(word - 4'(OFF_SET0 >> 2));
	wire [2:0] idx1 = 3'(word - 4'(OFF_SET1 >> 2));
	wire [DATA_W-1:0] merged0 = lanes(rd0, req.writedata, i_byteenable);
	wire [DATA_W-1:0] merged1 = lanes(rd1, req.writedata, i_byteenable);
	wire [DATA_W-1:0] hs_word = {{(DATA_W-HPOS_W){1'b0}}, iir_hstart};

	always_comb begin
		next_readdata = RST_WORD;
		if (hit_hs) begin
			next_readdata = hs_word;
		end else if (hit_base) begin
			next_readdata = pending_base;
		end else if (hit_s0) begin
			next_readdata = rd0;
		end else if (hit_s1) begin
			next_readdata = rd1;
		end
	end

	afir_coef_bank u_set0 (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_we(wr_go && hit_s0),
		.i_word(idx0),
		.i_wdata(merged0),
		.i_rword(idx0),
		.o_rdata(rd0),
		.o_taps(taps0)
	);
	// second set, same packing and range as the first
	afir_coef_bank u_set1 (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_we(wr_go && hit_s1),
		.i_word(idx1),
		.i_wdata(merged1),
		.i_rword(idx1),
		.o_rdata(rd1),
		.o_taps(taps1)
	);

	afir_hstart_clear u_clr (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_pix_valid(i_pix_valid),
		.i_hpos(i_hpos),
		.i_hstart(iir_hstart),
		.o_clear(o_iir_clear)
	);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			done <= 1'b0;
			o_waitrequest <= 1'b1;
			o_readdata <= RST_WORD;
			o_response <= 2'h0;
		end else begin
			done <= access;
			o_waitrequest <= !access;
			if (access) begin
				o_readdata <= req.read ? next_readdata : RST_WORD;
				o_response <= mapped ? 2'h0 : 2'h3;
			end
		end
	end

	// even values are the software's duty; stored as written
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			iir_hstart <= HPOS_W'(0);
		end else if (wr_go && hit_hs) begin
			iir_hstart <= HPOS_W'(lanes(hs_word, req.writedata,
				i_byteenable));
		end
	end

	// base is 64-byte aligned; six low bits dropped on write
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			pending_base <= RST_WORD;
		end else if (wr_go && hit_base) begin
			pending_base <= lanes(pending_base, req.writedata,
				i_byteenable) & BASE_MASK;
		end
	end

	// frame-boundary copy; a write in the same cycle waits a frame
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_active_base <= RST_WORD;
		end else if (i_frame_start) begin
			o_active_base <= pending_base;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_iir_hstart <= HPOS_W'(0);
			o_coef <= '0;
		end else begin
			o_iir_hstart <= iir_hstart;
			o_coef <= '{set0: taps0, set1: taps1};
		end
	end
	// paxel start vs iir start ordering is checked by software
endmodule

// [tb/afir_setup_regs_properties.sv]
`timescale 1ns/10ps
module afir_setup_regs_chk (
	// bus and video inputs
	input wire logic i_clk, i_srst, i_read, i_write, i_pix_valid,
	input wire logic i_frame_start,
	input wire logic [afir_pkg::ADDR_W-1:0] i_address,
	input wire logic [afir_pkg::HPOS_W-1:0] i_hpos, o_iir_hstart,
	// design outputs
	input wire logic [afir_pkg::DATA_W-1:0] o_readdata, o_active_base,
	input wire logic o_waitrequest, o_iir_clear,
	input wire logic [1:0] o_response
);
	import afir_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	wire rd_ok = i_read && !o_waitrequest;
	sequence s_match; i_pix_valid && i_hpos == o_iir_hstart; endsequence
	sequence s_next_pix; i_pix_valid; endsequence
	a_clear_after_match: assert property (
		s_match ##1 s_next_pix |=> o_iir_clear) else $error("no clear");
	a_active_align: assert property (
		o_active_base[5:0] == 6'h00) else $error("base low bits");
	a_base_frame_hold: assert property (
		!i_frame_start |=> $stable(o_active_base)) else $error("base moved");
	a_base_rd_align: assert property (
		rd_ok && i_address == OFF_BASE |-> o_readdata[5:0] == 6'h00)
		else $error("base read low bits");
	a_pair_rsv_zero: assert property (
		rd_ok && i_address >= OFF_SET0 |-> (o_readdata & ~PAIR_MASK) == '0)
		else $error("pair reserved bits");
	a_tap_ten_rsv: assert property (
		rd_ok && (i_address == 6'h1C || i_address == 6'h34)
		|-> o_readdata[31:12] == 20'h00000) else $error("tap ten upper");
	a_wait_one_cycle: assert property (
		!o_waitrequest |=> o_waitrequest) else $error("wait low too long");
	a_unmapped_err: assert property (
		rd_ok && i_address[5:2] > 4'hD |-> o_response == 2'b11)
		else $error("no decode error");
	// words 0 to 13 are all decoded, whatever the byte offset
	a_mapped_resp_ok: assert property (
		(i_read || i_write) && !o_waitrequest && i_address[5:2] < 4'hE
		|-> o_response == 2'b00) else $error("mapped access error");
endmodule
bind afir_setup_regs afir_setup_regs_chk chk_u (.i_clk, .i_srst, .i_read,
	.i_write, .i_pix_valid, .i_frame_start, .i_address, .i_hpos,
	.o_iir_hstart, .o_readdata, .o_active_base, .o_waitrequest,
	.o_iir_clear, .o_response);

// [tb/tb_top.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH at %0t: %h vs %h", $time, g, e); end end
module tb_top;
	import afir_pkg::*;
	logic i_clk = 0, i_srst = 1, i_read = 0, i_write = 0;
	logic i_frame_start = 0, i_pix_valid = 0, o_waitrequest, o_iir_clear;
	logic [ADDR_W-1:0] i_address = '0;
	logic [DATA_W-1:0] i_writedata = '0, o_readdata, o_active_base, q, d;
	logic [HPOS_W-1:0] i_hpos = '0, o_iir_hstart;
	logic [1:0] o_response, rsp;
	afir_coef_s o_coef;
	int failures, total_checks, cyc, nclr, t;
	always #5 i_clk = ~i_clk;
	afir_setup_regs dut_u (.i_clk, .i_srst, .i_read, .i_write, .i_address,
		.i_writedata, .i_byteenable(4'hF), .o_readdata, .o_waitrequest,
		.o_response, .i_frame_start, .i_pix_valid, .i_hpos, .o_iir_clear,
		.o_iir_hstart, .o_active_base, .o_coef);
	task summarize();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// request held until waitrequest is seen low at a rising edge
	task acc(input logic w, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] wd);
		@(posedge i_clk);
		i_read <= !w;
		i_write <= w;
		i_address <= a;
		i_writedata <= wd;
		do @(posedge i_clk); while (o_waitrequest !== 1'b0);
		q = o_readdata;
		rsp = o_response;
		i_read <= 0;
		i_write <= 0;
	endtask
	always @(posedge i_clk) begin
		cyc++;
		nclr += (o_iir_clear === 1'b1);
		if (cyc == 2000) begin
			failures++;
			$display("MISMATCH at %0t: timeout", $time);
			summarize();
		end
	end
	initial begin
		repeat (12) @(posedge i_clk);
		i_srst <= 0;
		for (int a = 0; a < 14; a++) begin
			acc(0, 6'(a * 4), '0);
			`CHK(q, 32'h0000_0000)
			`CHK(rsp, 2'b00)
		end
		acc(1, OFF_HSTART, 32'hFFFF_F00A);
		acc(0, OFF_HSTART, '0);
		`CHK(q, 32'h0000_000A)
		`CHK(o_iir_hstart, 12'h00A)
		for (int h = 0; h < 24; h++) begin
			@(posedge i_clk);
			i_pix_valid <= 1;
			i_hpos <= h[HPOS_W-1:0];
		end
		@(posedge i_clk);
		i_pix_valid <= 0;
		`CHK(nclr, 1)
		acc(1, OFF_BASE, 32'h1234_5678);
		@(posedge i_clk);
		i_frame_start <= 1;
		@(posedge i_clk);
		i_frame_start <= 0;
		@(negedge i_clk);
		`CHK(o_active_base, 32'h1234_5640)
		acc(1, OFF_BASE, 32'hFFFF_FFFF);
		acc(0, OFF_BASE, '0);
		`CHK(q, 32'hFFFF_FFC0)
		`CHK(o_active_base, 32'h1234_5640)
		@(posedge i_clk);
		i_frame_start <= 1;
		@(posedge i_clk);
		i_frame_start <= 0;
		@(negedge i_clk);
		`CHK(o_active_base, 32'hFFFF_FFC0)
		// extremes -32 in even taps and just under +32 in odd taps, offset per word
		for (int w = 0; w < 12; w++) begin
			d = 32'hF7F0_F800 + w * 32'h0001_0001;
			t = (w % 6) * 2;
			acc(1, OFF_SET0 + 6'(w * 4), d);
			acc(0, OFF_SET0 + 6'(w * 4), '0);
			`CHK(q, d & ((w % 6 == 5) ? HSTART_MASK : PAIR_MASK))
			`CHK(w < 6 ? o_coef.set0[t] : o_coef.set1[t], d[11:0])
			if (t < 10)
				`CHK(w < 6 ? o_coef.set0[t+1] : o_coef.set1[t+1], d[27:16])
		end
		acc(1, 6'h38, 32'hFFFF_FFFF);
		`CHK(rsp, 2'b11)
		acc(0, 6'h38, '0);
		`CHK({rsp, q}, {2'b11, 32'h0000_0000})
		summarize();
	end
endmodule
